// ==== common/bbp_pkg.sv ====
package bbp_pkg;
    // register byte addresses
    localparam logic [7:0] BOOST_SLOPE_MODE_ADDR = 8'hA2;
    localparam logic [7:0] UV_PHASE_FREQ_ADDR = 8'hA3;
    localparam logic [7:0] SLOPE_HEADROOM_ADDR = 8'hA4;
    localparam logic [7:0] BOOST_LEVEL_ADDR = 8'hA8;
    localparam logic [7:0] STATUS_ADDR = 8'hAC;
    localparam logic [7:0] ADDR_MASK = 8'hFF;
    // reset values
    localparam logic [7:0] BOOST_SLOPE_MODE_RST = 8'h00;
    localparam logic [7:0] UV_PHASE_FREQ_RST = 8'h00;
    localparam logic [7:0] SLOPE_HEADROOM_RST = 8'h00;
    localparam logic [7:0] BOOST_LEVEL_RST = 8'h00;
    // field positions, boost_slope_mode_config
    localparam int SLOPE_HI_BIT = 0;
    localparam int CURRENT_LIMIT_BIT = 1;
    localparam int BOOST_EN_BIT = 2;
    localparam int ADAPT_BIT = 3;
    localparam int MODE25_BIT = 4;
    // field positions, slope/headroom byte
    localparam int SLOPE_LO_BIT = 3;
    localparam int HEADROOM_MSB = 2;
    localparam int HEADROOM_LSB = 0;
    // field positions, undervoltage_phase_freq_config
    localparam int LOCKOUT_MSB = 7;
    localparam int LOCKOUT_LSB = 6;
    localparam int PHASE_BIT = 5;
    localparam int RATE_MSB = 4;
    localparam int RATE_LSB = 0;
    // lockout codes
    localparam logic [1:0] LOCKOUT_OFF = 2'h0;
    localparam logic [1:0] LOCKOUT_2V7 = 2'h1;
    localparam logic [1:0] LOCKOUT_5V4 = 2'h2;
    localparam logic [1:0] LOCKOUT_8V1 = 2'h3;
    // slope trim in units of 0.125 percent reduction
    localparam logic [6:0] SLOPE_STEP_25 = 7'h14;
    localparam logic [6:0] SLOPE_STEP_50 = 7'h0A;
endpackage : bbp_pkg

// ==== logic/bbp_sync.sv ====
`timescale 1ns/10ps
`default_nettype none
module bbp_sync (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic din,
    output logic dout
);
    logic stage1;
    logic next_stage1;
    logic next_dout;

    always_comb begin
        next_stage1 = din;
        next_dout = stage1;
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            stage1 <= 1'b0;
            dout <= 1'b0;
        end else begin
            stage1 <= next_stage1;
            dout <= next_dout;
        end
    end
endmodule : bbp_sync
`default_nettype wire

// ==== logic/bbp_config.sv ====
// Functional notes
// RULE1 - adaptive off: boost held at programmed level
// RULE2 - adaptive on: startup level, then track headroom
// RULE3 - boost enable: auto-on with backlight enable
// RULE4 - slope trim lowers current, 25/50 scaled
// RULE5 - phase bit selects phase-shifted or normal PWM
// RULE6 - five-bit output pulse rate code
// RULE7 - lockout field: off, 2.7, 5.4, 8.1 V
//
// Local design decision: the APB slave port.
`timescale 1ns/10ps
`default_nettype none
module bbp_config (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic backlight_enable,
    input wire logic startup_reached,
    input wire logic [7:0] tracked_level,
    output logic boost_on,
    output logic adaptive_tracking,
    output logic [7:0] boost_target,
    output logic [2:0] headroom_code,
    output logic inductor_current_limit,
    output logic mode25_select,
    output logic [6:0] slope_reduction,
    output logic phase_shifted_drive_on,
    output logic [4:0] output_pulse_rate_code,
    output logic lockout_enable,
    output logic [1:0] low_supply_lockout_level
);
    typedef enum logic [1:0] {BOOST_OFF, BOOST_STARTUP, BOOST_TRACK} bbp_boost_t;

    logic rstSync1;
    logic rstCore;
    logic blEnable;
    logic startDone;
    logic [7:0] boostSlopeMode;
    logic [7:0] uvPhaseFreq;
    logic [7:0] slopeHeadroom;
    logic [7:0] boostLevel;
    logic [7:0] next_boostSlopeMode;
    logic [7:0] next_uvPhaseFreq;
    logic [7:0] next_slopeHeadroom;
    logic [7:0] next_boostLevel;
    bbp_boost_t boostState;
    bbp_boost_t next_boostState;
    logic [31:0] next_prdata;
    logic next_pready;
    logic next_pslverr;
    logic [7:0] next_boostTarget;
    logic [6:0] next_slopeReduction;
    logic [1:0] slopeCode;
    logic hit;
    logic [7:0] addr;

    function automatic logic [6:0] bbp_slope(input logic [1:0] code, input logic sel25);
        logic [6:0] step;
        step = sel25 ? bbp_pkg::SLOPE_STEP_25 : bbp_pkg::SLOPE_STEP_50;
        bbp_slope = 7'((({5'h00, code} + 7'h01) * step));
    endfunction : bbp_slope

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            rstSync1 <= 1'b0;
            rstCore <= 1'b0;
        end else begin
            rstSync1 <= 1'b1;
            rstCore <= rstSync1;
        end
    end

    bbp_sync u_bl_sync (
        .core_clk(core_clk),
        .rst_b(rstCore),
        .din(backlight_enable),
        .dout(blEnable)
    );

    bbp_sync u_start_sync (
        .core_clk(core_clk),
        .rst_b(rstCore),
        .din(startup_reached),
        .dout(startDone)
    );

    assign addr = paddr[7:0];
    assign slopeCode = {boostSlopeMode[bbp_pkg::SLOPE_HI_BIT],
                        slopeHeadroom[bbp_pkg::SLOPE_LO_BIT]};

    // register bank, single-wait apb slave
    always_comb begin
        next_boostSlopeMode = boostSlopeMode;
        next_uvPhaseFreq = uvPhaseFreq;
        next_slopeHeadroom = slopeHeadroom;
        next_boostLevel = boostLevel;
        next_prdata = prdata;
        next_pslverr = 1'b0;
        next_pready = 1'b0;
        hit = (paddr[31:8] == 24'h000000);
        if (psel && penable && !pready) begin
            next_pready = 1'b1;
            next_prdata = 32'h00000000;
            case (addr)
                bbp_pkg::BOOST_SLOPE_MODE_ADDR: begin
                    if (pwrite) next_boostSlopeMode = pwdata[7:0];
                    next_prdata = {24'h000000, boostSlopeMode};
                end
                bbp_pkg::UV_PHASE_FREQ_ADDR: begin
                    if (pwrite) next_uvPhaseFreq = pwdata[7:0];
                    next_prdata = {24'h000000, uvPhaseFreq};
                end
                bbp_pkg::SLOPE_HEADROOM_ADDR: begin
                    if (pwrite) next_slopeHeadroom = pwdata[7:0];
                    next_prdata = {24'h000000, slopeHeadroom};
                end
                bbp_pkg::BOOST_LEVEL_ADDR: begin
                    if (pwrite) next_boostLevel = pwdata[7:0];
                    next_prdata = {24'h000000, boostLevel};
                end
                bbp_pkg::STATUS_ADDR: begin
                    next_prdata = {29'h0000000, blEnable, boostState};
                    next_pslverr = pwrite;
                end
                default: begin
                    next_pslverr = 1'b1;
                end
            endcase
            if (!hit) begin
                next_boostSlopeMode = boostSlopeMode;
                next_uvPhaseFreq = uvPhaseFreq;
                next_slopeHeadroom = slopeHeadroom;
                next_boostLevel = boostLevel;
                next_prdata = 32'h00000000;
                next_pslverr = 1'b1;
            end
        end
    end

    // boost sequencing
    always_comb begin
        next_boostState = boostState;
        case (boostState)
            BOOST_OFF: begin
                if (boostSlopeMode[bbp_pkg::BOOST_EN_BIT] && blEnable) begin // RULE3
                    next_boostState = BOOST_STARTUP;
                end
            end
            BOOST_STARTUP: begin
                if (boostSlopeMode[bbp_pkg::ADAPT_BIT] && startDone) begin // RULE2
                    next_boostState = BOOST_TRACK;
                end
            end
            BOOST_TRACK: begin
                if (!boostSlopeMode[bbp_pkg::ADAPT_BIT]) begin // RULE1
                    next_boostState = BOOST_STARTUP;
                end
            end
            default: next_boostState = BOOST_OFF;
        endcase
        if (!boostSlopeMode[bbp_pkg::BOOST_EN_BIT] || !blEnable) begin // RULE3
            next_boostState = BOOST_OFF;
        end
        next_boostTarget = boostLevel; // RULE1
        if (next_boostState == BOOST_TRACK) begin
            next_boostTarget = tracked_level; // RULE2
        end
        next_slopeReduction = bbp_slope(slopeCode,
                                        boostSlopeMode[bbp_pkg::MODE25_BIT]); // RULE4
    end

    always_ff @(posedge core_clk or negedge rstCore) begin
        if (!rstCore) begin
            boostSlopeMode <= bbp_pkg::BOOST_SLOPE_MODE_RST;
            uvPhaseFreq <= bbp_pkg::UV_PHASE_FREQ_RST;
            slopeHeadroom <= bbp_pkg::SLOPE_HEADROOM_RST;
            boostLevel <= bbp_pkg::BOOST_LEVEL_RST;
            prdata <= 32'h00000000;
            pready <= 1'b0;
            pslverr <= 1'b0;
            boostState <= BOOST_OFF;
            boost_on <= 1'b0;
            adaptive_tracking <= 1'b0;
            boost_target <= 8'h00;
            headroom_code <= 3'h0;
            inductor_current_limit <= 1'b0;
            mode25_select <= 1'b0;
            slope_reduction <= 7'h00;
            phase_shifted_drive_on <= 1'b0;
            output_pulse_rate_code <= 5'h00;
            lockout_enable <= 1'b0;
            low_supply_lockout_level <= bbp_pkg::LOCKOUT_OFF;
        end else begin
            boostSlopeMode <= next_boostSlopeMode;
            uvPhaseFreq <= next_uvPhaseFreq;
            slopeHeadroom <= next_slopeHeadroom;
            boostLevel <= next_boostLevel;
            prdata <= next_prdata;
            pready <= next_pready;
            pslverr <= next_pslverr;
            boostState <= next_boostState;
            boost_on <= (next_boostState != BOOST_OFF); // RULE3
            adaptive_tracking <= (next_boostState == BOOST_TRACK); // RULE2
            boost_target <= next_boostTarget;
            headroom_code <= slopeHeadroom[bbp_pkg::HEADROOM_MSB:bbp_pkg::HEADROOM_LSB]; // RULE2
            inductor_current_limit <= boostSlopeMode[bbp_pkg::CURRENT_LIMIT_BIT];
            mode25_select <= boostSlopeMode[bbp_pkg::MODE25_BIT]; // RULE4
            slope_reduction <= next_slopeReduction; // RULE4
            phase_shifted_drive_on <= uvPhaseFreq[bbp_pkg::PHASE_BIT]; // RULE5
            output_pulse_rate_code <= uvPhaseFreq[bbp_pkg::RATE_MSB:bbp_pkg::RATE_LSB]; // RULE6
            lockout_enable <= (uvPhaseFreq[bbp_pkg::LOCKOUT_MSB:bbp_pkg::LOCKOUT_LSB]
                               != bbp_pkg::LOCKOUT_OFF); // RULE7
            low_supply_lockout_level <= uvPhaseFreq[bbp_pkg::LOCKOUT_MSB:bbp_pkg::LOCKOUT_LSB]; // RULE7
        end
    end
endmodule : bbp_config
`default_nettype wire

// ==== tb/bbp_monitor.sv ====
`timescale 1ns/10ps
`default_nettype none
module bbp_monitor (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic backlight_enable,
    input wire logic boost_on,
    input wire logic adaptive_tracking,
    input wire logic [7:0] boost_target,
    input wire logic [7:0] tracked_level,
    input wire logic mode25_select,
    input wire logic [6:0] slope_reduction,
    input wire logic lockout_enable,
    input wire logic [1:0] low_supply_lockout_level
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    chk_ready_wait: assert property (psel && penable && !pready |=> pready)
        else $error("pready late");
    chk_ready_pulse: assert property (pready |=> !pready)
        else $error("pready too long");
    chk_err_pulse: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    chk_slope_value: assert property (slope_reduction != 7'h00 |-> (mode25_select ?
        slope_reduction inside {7'h14, 7'h28, 7'h3C, 7'h50} :
        slope_reduction inside {7'h0A, 7'h14, 7'h1E, 7'h28}))
        else $error("slope value");
    chk_lockout_en: assert property (lockout_enable == (low_supply_lockout_level != 2'h0))
        else $error("lockout enable");
    chk_boost_idle: assert property (!backlight_enable [*4] |-> !boost_on)
        else $error("boost on without backlight");
    chk_boost_delay: assert property ($rose(boost_on) |-> $past(backlight_enable, 3))
        else $error("boost rose early");
    chk_track_target: assert property (adaptive_tracking && $past(adaptive_tracking) &&
        $stable(tracked_level) |-> boost_target == tracked_level)
        else $error("tracking target");
    chk_fixed_target: assert property (!adaptive_tracking && !$past(adaptive_tracking) &&
        !$past(adaptive_tracking, 2) && !$past(pready) |-> $stable(boost_target))
        else $error("fixed target moved");
    chk_track_boost: assert property ($rose(adaptive_tracking) |-> $past(boost_on))
        else $error("tracking without startup");
    cover property ($rose(boost_on));
    cover property ($rose(adaptive_tracking));
    cover property (pslverr);
endmodule : bbp_monitor
bind bbp_config bbp_monitor u_mon (.core_clk, .rst_b, .psel, .penable, .pready, .pslverr,
    .backlight_enable, .boost_on, .adaptive_tracking, .boost_target, .tracked_level,
    .mode25_select, .slope_reduction, .lockout_enable, .low_supply_lockout_level);
`default_nettype wire

// ==== tb/testbench.sv ====
`timescale 1ns/10ps
`default_nettype none
module testbench;
    logic core_clk, rst_b, psel, penable, pwrite, pready, pslverr, err;
    logic backlight_enable, startup_reached, boost_on, adaptive_tracking;
    logic inductor_current_limit, mode25_select, phase_shifted_drive_on, lockout_enable;
    logic [31:0] paddr, pwdata, prdata, rd;
    logic [7:0] tracked_level, boost_target, lvl;
    logic [7:0] m [0:255];
    logic [6:0] slope_reduction;
    logic [4:0] output_pulse_rate_code;
    logic [2:0] headroom_code;
    logic [1:0] low_supply_lockout_level;
    int failCount = 0;
    int totalChecks = 0;
    int seed = 55859;
    int cycles = 0;
    bbp_config dut (.core_clk, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .backlight_enable, .startup_reached, .tracked_level, .boost_on,
        .adaptive_tracking, .boost_target, .headroom_code, .inductor_current_limit,
        .mode25_select, .slope_reduction, .phase_shifted_drive_on, .output_pulse_rate_code,
        .lockout_enable, .low_supply_lockout_level);
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    task automatic finishTest;
        $display("checks %0d mismatches %0d", totalChecks, failCount);
        if (failCount == 0 && totalChecks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : finishTest
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            failCount++;
            finishTest();
        end
    end
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        totalChecks++;
        if (g !== e) begin
            failCount++;
            $display("BAD %s exp %h got %h", n, e, g);
        end
    endtask : chk
    task automatic wt(input int n);
        repeat (n) @(posedge core_clk);
    endtask : wt
    // one apb transfer, request held until pready seen at an edge
    task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        do @(posedge core_clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge core_clk);
    endtask : apb
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        apb(1'b1, {24'h0, a}, {24'h0, d});
        m[a] = d;
        chk("wr err", 0, err);
    endtask : wr
    task automatic rdc(input logic [7:0] a);
        apb(1'b0, {24'h0, a}, 32'h0);
        chk("rd err", 0, err);
        chk("rd data", {24'h0, m[a]}, rd);
    endtask : rdc
    initial begin
        rst_b = 1'b0;
        {psel, penable, pwrite, backlight_enable, startup_reached} = 5'h00;
        paddr = 32'h0;
        pwdata = 32'h0;
        tracked_level = 8'h00;
        foreach (m[k]) m[k] = 8'h00;
        wt(16);
        rst_b <= 1'b1;
        wt(4);
        rdc(bbp_pkg::BOOST_SLOPE_MODE_ADDR);
        rdc(bbp_pkg::UV_PHASE_FREQ_ADDR);
        rdc(bbp_pkg::SLOPE_HEADROOM_ADDR);
        rdc(bbp_pkg::BOOST_LEVEL_ADDR);
        rdc(bbp_pkg::STATUS_ADDR);
        apb(1'b0, 32'h000000A0, 32'h0);
        chk("unmapped err", 1, err);
        chk("unmapped data", 0, rd);
        apb(1'b1, 32'h000001A2, 32'hFF);
        chk("high addr err", 1, err);
        apb(1'b1, {24'h0, bbp_pkg::STATUS_ADDR}, 32'hFF);
        chk("status wr err", 1, err);
        rdc(bbp_pkg::BOOST_SLOPE_MODE_ADDR);
        $display("test reset and refusal done");
        for (int i = 0; i < 4; i++) begin
            lvl = {i[1:0], 6'($random(seed))};
            wr(bbp_pkg::UV_PHASE_FREQ_ADDR, lvl);
            rdc(bbp_pkg::UV_PHASE_FREQ_ADDR);
            chk("lockout", i, low_supply_lockout_level);
            chk("lockout on", i != 0, lockout_enable);
            chk("phase", lvl[5], phase_shifted_drive_on);
            chk("rate", lvl[4:0], output_pulse_rate_code);
        end
        $display("test lockout phase rate done");
        for (int i = 0; i < 8; i++) begin
            lvl = 8'($random(seed));
            wr(bbp_pkg::BOOST_SLOPE_MODE_ADDR, {3'h0, i[2], 3'h0, i[1]});
            wr(bbp_pkg::SLOPE_HEADROOM_ADDR, {4'h0, i[0], lvl[2:0]});
            wt(2);
            chk("slope", (i[1:0] + 1) * (i[2] ? 20 : 10), slope_reduction);
            chk("mode", i[2], mode25_select);
            chk("headroom", lvl[2:0], headroom_code);
        end
        $display("test slope done");
        tracked_level <= 8'($random(seed));
        lvl = 8'($random(seed));
        wr(bbp_pkg::BOOST_LEVEL_ADDR, lvl);
        wr(bbp_pkg::BOOST_SLOPE_MODE_ADDR, 8'h04);
        wt(6);
        chk("boost idle", 0, boost_on);
        backlight_enable <= 1'b1;
        wt(6);
        chk("boost on", 1, boost_on);
        chk("fixed target", lvl, boost_target);
        chk("no tracking", 0, adaptive_tracking);
        m[bbp_pkg::STATUS_ADDR] = 8'h05;
        rdc(bbp_pkg::STATUS_ADDR);
        wr(bbp_pkg::BOOST_SLOPE_MODE_ADDR, 8'h0E);
        wt(6);
        chk("startup wait", 0, adaptive_tracking);
        chk("startup target", lvl, boost_target);
        startup_reached <= 1'b1;
        wt(6);
        chk("tracking", 1, adaptive_tracking);
        chk("track target", tracked_level, boost_target);
        chk("imax", 1, inductor_current_limit);
        m[bbp_pkg::STATUS_ADDR] = 8'h06;
        rdc(bbp_pkg::STATUS_ADDR);
        tracked_level <= 8'($random(seed));
        wt(2);
        chk("track follow", tracked_level, boost_target);
        wr(bbp_pkg::BOOST_SLOPE_MODE_ADDR, 8'h06);
        wt(6);
        chk("track left", 0, adaptive_tracking);
        chk("back to fixed", lvl, boost_target);
        chk("boost kept", 1, boost_on);
        m[bbp_pkg::STATUS_ADDR] = 8'h05;
        rdc(bbp_pkg::STATUS_ADDR);
        wr(bbp_pkg::BOOST_SLOPE_MODE_ADDR, 8'h08);
        wt(6);
        chk("boost disabled", 0, boost_on);
        backlight_enable <= 1'b0;
        wt(6);
        $display("test boost done");
        finishTest();
    end
endmodule : testbench
`default_nettype wire
